//--- rtl/aslc_sleep_lock_ctrl.sv
// Behaviour
// RQ1 - Sleep kind at control bits 12:10; 110 and 111 reserved.
// RQ2 - Writing one to sleep_go starts entry into chosen sleep kind; reads zero.
// RQ3 - Sleep entry waits until a management interrupt was generated and serviced.
// RQ4 - Control bit 2 is write-only, reads zero, raises firmware event.
// RQ5 - Global release write also sets firmware status flag at 0Eh bit 0.
// RQ6 - Global release raises management interrupt only when 0Fh bit 0 set.
// RQ7 - Such interrupt records top status and second-level status bit 5.
// RQ8 - With bit 1 set, bus master request in C3 forces C0.
// RQ9 - Legacy mode sends events to management interrupt; ACPI mode to enabled SYSTEM_CONTROL_INTERRUPT.
// RQ10 - SYSTEM_CONTROL_INTERRUPT enable also enables the whole sleep state machine.
// RQ11 - Firmware lock release sets global lock status, event, SYSTEM_CONTROL_INTERRUPT if enabled.
// RQ12 - General event status is sole status level, except GPIO summary bit 3.
// RQ13 - Software writes zero to reserved bits of 0Eh and 0Fh.
// RQ14 - Sleep go with reserved kind causes no transition.
// RQ15 - Write-one-to-clear bits clear only ones written; set beats clear.
`timescale 1ns/1ps
module aslc_sleep_lock_ctrl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // I/O register port
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_addr,
  input wire logic [1:0] io_be,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  // Event sources
  input wire logic [15:0] gen_event_in,
  input wire logic [15:0] gen_event_enable,
  input wire logic smi_serviced,
  input wire logic wake_event,
  // Processor and bus master
  input wire logic cpu_in_c3,
  input wire logic bus_master_req_pin,
  output logic force_c0,
  // Interrupts and status reports
  output logic management_interrupt,
  output logic smi_top_status_set,
  output logic smi_top_legacy_set,
  output logic smi_second_lock_set,
  output logic system_control_interrupt,
  output logic power_mgmt_event,
  // Sleep state
  output logic sleep_active,
  output logic [2:0] sleep_kind_out
);
  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  logic wr_ctrl;
  logic wr_pwr_sts;
  logic wr_pwr_en;
  logic wr_fw_lo;
  logic wr_fw_hi;
  logic wr_gen;
  logic [15:0] wmask;

  assign wmask = {{8{io_be[1]}}, {8{io_be[0]}}};
  assign wr_ctrl = io_wr && (io_addr == aslc_pkg::OFS_SLEEP_PWR_CTRL);
  assign wr_pwr_sts = io_wr && (io_addr == aslc_pkg::OFS_PWR_EVT_STATUS);
  assign wr_pwr_en = io_wr && (io_addr == aslc_pkg::OFS_PWR_EVT_ENABLE);
  assign wr_fw_lo = io_wr && (io_addr == aslc_pkg::OFS_FW_RELEASE) && io_be[0];
  assign wr_fw_hi = io_wr && (io_addr == aslc_pkg::OFS_FW_RELEASE) && io_be[1];
  assign wr_gen = io_wr && (io_addr == aslc_pkg::OFS_GEN_EVT_STATUS);

  // ----------------------------------------
  // Control register 0Ch
  // ----------------------------------------
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic system_ctrl_irq_enable;
  logic bm_exit_en;
  logic [2:0] sleep_kind_field;

  // Only stored bits are held; write-only strobes never land here
  assign ctrl_next = (ctrl_reg & ~(wmask & aslc_pkg::CTRL_RW_MASK)) |
                     (io_wdata & wmask & aslc_pkg::CTRL_RW_MASK);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctrl_reg <= aslc_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign system_ctrl_irq_enable = ctrl_reg[aslc_pkg::BIT_SYS_IRQ_EN];
  assign bm_exit_en = ctrl_reg[aslc_pkg::BIT_BM_C3_EXIT];
  assign sleep_kind_field = ctrl_reg[aslc_pkg::KIND_MSB:aslc_pkg::KIND_LSB]; // RQ1

  logic sleep_go;
  logic global_release_to_firmware;
  logic [2:0] new_kind;

  assign new_kind = io_be[1] ? io_wdata[aslc_pkg::KIND_MSB:aslc_pkg::KIND_LSB]
                             : sleep_kind_field;
  assign sleep_go = wr_ctrl && io_be[1] && io_wdata[aslc_pkg::BIT_SLEEP_GO]; // RQ2
  assign global_release_to_firmware = wr_ctrl && io_be[0] &&
                                      io_wdata[aslc_pkg::BIT_GLOBAL_RELEASE]; // RQ4

  // ----------------------------------------
  // Firmware release registers 0Eh / 0Fh
  // ----------------------------------------
  logic [7:0] fw_status;
  logic [7:0] fw_set;
  logic [7:0] fw_clr;
  logic [7:0] fw_enable_reg;
  logic firmware_smi_enable;
  logic firmware_lock_release;

  // Reserved bits 7:1 never set, so they read zero whatever is written
  assign fw_set = {7'h00, global_release_to_firmware}; // RQ5
  assign fw_clr = wr_fw_lo ? io_wdata[7:0] : 8'h00; // RQ15

  aslc_w1c_bits #(
    .W(8),
    .RESET_VAL(aslc_pkg::FW_STATUS_RESET)
  ) u_fw_status (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .set_bits(fw_set),
    .clr_bits(fw_clr),
    .flags(fw_status)
  );

  // Reserved bits 7:2 kept at zero even if software ignores the rule
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      fw_enable_reg <= aslc_pkg::FW_ENABLE_RESET;
    end else if (wr_fw_hi) begin
      fw_enable_reg <= {7'h00, io_wdata[8 + aslc_pkg::BIT_FW_SMI_EN]}; // RQ13
    end
  end

  assign firmware_smi_enable = fw_enable_reg[aslc_pkg::BIT_FW_SMI_EN];
  assign firmware_lock_release = wr_fw_hi &&
                                 io_wdata[8 + aslc_pkg::BIT_FW_LOCK_RELEASE]; // RQ11

  // ----------------------------------------
  // Power event status 08h and enable 0Ah
  // ----------------------------------------
  logic [15:0] pwr_status;
  logic [15:0] pwr_set;
  logic [15:0] pwr_clr;
  logic [15:0] pwr_en_reg;

  assign pwr_set = {10'h000, firmware_lock_release, 5'h00}; // RQ11
  assign pwr_clr = wr_pwr_sts ? (io_wdata & wmask) : 16'h0000;

  aslc_w1c_bits #(
    .W(16),
    .RESET_VAL(aslc_pkg::PWR_EVT_STS_RESET)
  ) u_pwr_status (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .set_bits(pwr_set),
    .clr_bits(pwr_clr),
    .flags(pwr_status)
  );

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pwr_en_reg <= aslc_pkg::PWR_EVT_EN_RESET;
    end else if (wr_pwr_en) begin
      pwr_en_reg <= (pwr_en_reg & ~(wmask & aslc_pkg::PWR_EVT_EN_MASK)) |
                    (io_wdata & wmask & aslc_pkg::PWR_EVT_EN_MASK);
    end
  end

  // ----------------------------------------
  // General event status 10h
  // ----------------------------------------
  logic [15:0] gen_status;
  logic [15:0] gen_set;
  logic [15:0] gen_clr;

  // Sole status level; bit 3 only summarises a lower GPIO level
  assign gen_set = gen_event_in & aslc_pkg::GEN_EVT_MASK; // RQ12
  assign gen_clr = wr_gen ? (io_wdata & wmask) : 16'h0000;

  aslc_w1c_bits #(
    .W(16),
    .RESET_VAL(aslc_pkg::GEN_EVT_RESET)
  ) u_gen_status (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .set_bits(gen_set),
    .clr_bits(gen_clr),
    .flags(gen_status)
  );

  // ----------------------------------------
  // Interrupt routing
  // ----------------------------------------
  logic lock_smi;
  logic legacy_smi;

  assign lock_smi = global_release_to_firmware && firmware_smi_enable; // RQ6
  assign legacy_smi = !system_ctrl_irq_enable && (|gen_set || firmware_lock_release); // RQ9

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      management_interrupt <= 1'b0;
      smi_top_status_set <= 1'b0;
      smi_top_legacy_set <= 1'b0;
      smi_second_lock_set <= 1'b0;
      power_mgmt_event <= 1'b0;
    end else begin
      management_interrupt <= lock_smi || legacy_smi; // RQ4
      smi_top_status_set <= lock_smi; // RQ7
      smi_second_lock_set <= lock_smi; // RQ7
      smi_top_legacy_set <= legacy_smi; // RQ9
      power_mgmt_event <= firmware_lock_release || |gen_set; // RQ11
    end
  end

  // Level SYSTEM_CONTROL_INTERRUPT; status still latches when SYSTEM_CONTROL_INTERRUPT is off, for polling
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      system_control_interrupt <= 1'b0;
    end else begin
      system_control_interrupt <= system_ctrl_irq_enable && // RQ10
        (|(pwr_status & pwr_en_reg) || |(gen_status & gen_event_enable)); // RQ9 RQ11
    end
  end

  // ----------------------------------------
  // Bus master C3 exit
  // ----------------------------------------
  logic bm_req;
  logic bm_req_prev_reg;

  aslc_pin_sync u_bm_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pin_in(bus_master_req_pin),
    .level_out(bm_req)
  );

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      bm_req_prev_reg <= 1'b0;
      force_c0 <= 1'b0;
    end else begin
      bm_req_prev_reg <= bm_req;
      force_c0 <= bm_exit_en && cpu_in_c3 && bm_req && !bm_req_prev_reg; // RQ8
    end
  end

  // ----------------------------------------
  // Sleep state machine
  // ----------------------------------------
  aslc_pkg::aslc_state_t state_reg;
  aslc_pkg::aslc_state_t state_next;
  logic [2:0] kind_reg;
  logic kind_ok;

  // Full-on kind needs no sequencing
  assign kind_ok = (new_kind != aslc_pkg::KIND_RSVD_A) && (new_kind != aslc_pkg::KIND_RSVD_B) &&
                   (new_kind != aslc_pkg::KIND_FULL_ON); // RQ14

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      aslc_pkg::ASLC_WORK: begin
        if (sleep_go && system_ctrl_irq_enable && kind_ok) begin
          state_next = aslc_pkg::ASLC_WAIT_SMI; // RQ2 RQ10 RQ14
        end
      end
      aslc_pkg::ASLC_WAIT_SMI: begin
        if (!system_ctrl_irq_enable) begin
          state_next = aslc_pkg::ASLC_WORK; // RQ10
        end else if (smi_serviced) begin
          state_next = aslc_pkg::ASLC_SLEEPING; // RQ3
        end
      end
      aslc_pkg::ASLC_SLEEPING: begin
        if (wake_event || !system_ctrl_irq_enable) begin
          state_next = aslc_pkg::ASLC_WORK;
        end
      end
      default: begin
        state_next = aslc_pkg::ASLC_WORK;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_reg <= aslc_pkg::ASLC_WORK;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      kind_reg <= aslc_pkg::KIND_FULL_ON;
    end else if (state_reg == aslc_pkg::ASLC_WORK && state_next == aslc_pkg::ASLC_WAIT_SMI) begin
      kind_reg <= new_kind; // RQ1
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sleep_active <= 1'b0;
      sleep_kind_out <= aslc_pkg::KIND_FULL_ON;
    end else begin
      sleep_active <= (state_next == aslc_pkg::ASLC_SLEEPING);
      sleep_kind_out <= (state_next == aslc_pkg::ASLC_SLEEPING) ? kind_reg
                                                                : aslc_pkg::KIND_FULL_ON;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Write-only bits 13 and 2 and 0Fh bit 1 are never stored, so read zero
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      io_rdata <= 16'h0000;
    end else if (io_rd) begin
      case (io_addr)
        aslc_pkg::OFS_PWR_EVT_STATUS: io_rdata <= pwr_status;
        aslc_pkg::OFS_PWR_EVT_ENABLE: io_rdata <= pwr_en_reg;
        aslc_pkg::OFS_SLEEP_PWR_CTRL: io_rdata <= ctrl_reg; // RQ2 RQ4
        aslc_pkg::OFS_FW_RELEASE: io_rdata <= {fw_enable_reg, fw_status};
        aslc_pkg::OFS_GEN_EVT_STATUS: io_rdata <= gen_status;
        default: io_rdata <= 16'h0000;
      endcase
    end
  end
endmodule // aslc_sleep_lock_ctrl

//--- rtl/aslc_pkg.sv
package aslc_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses, word aligned)
  // ----------------------------------------
  localparam logic [7:0] OFS_PWR_EVT_STATUS = 8'h08;
  localparam logic [7:0] OFS_PWR_EVT_ENABLE = 8'h0a;
  localparam logic [7:0] OFS_SLEEP_PWR_CTRL = 8'h0c;
  localparam logic [7:0] OFS_FW_RELEASE = 8'h0e;
  localparam logic [7:0] OFS_GEN_EVT_STATUS = 8'h10;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_SYS_IRQ_EN = 0;
  localparam int BIT_BM_C3_EXIT = 1;
  localparam int BIT_GLOBAL_RELEASE = 2;
  localparam int KIND_LSB = 10;
  localparam int KIND_MSB = 12;
  localparam int BIT_SLEEP_GO = 13;
  localparam int BIT_FW_STATUS_FLAG = 0;
  localparam int BIT_FW_SMI_EN = 0;
  localparam int BIT_FW_LOCK_RELEASE = 1;
  localparam int BIT_GLOBAL_LOCK = 5;

  // ----------------------------------------
  // Writable masks and reset values
  // ----------------------------------------
  localparam logic [15:0] CTRL_RW_MASK = 16'h1c03;
  localparam logic [15:0] PWR_EVT_EN_MASK = 16'h0020;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] PWR_EVT_EN_RESET = 16'h0000;
  localparam logic [15:0] PWR_EVT_STS_RESET = 16'h0000;
  localparam logic [7:0] FW_STATUS_RESET = 8'h00;
  localparam logic [7:0] FW_ENABLE_RESET = 8'h00;
  localparam logic [15:0] GEN_EVT_RESET = 16'h0000;
  localparam logic [15:0] GEN_EVT_MASK = 16'h077d;

  // ----------------------------------------
  // Sleep kinds
  // ----------------------------------------
  localparam logic [2:0] KIND_FULL_ON = 3'h0;
  localparam logic [2:0] KIND_SL1 = 3'h1;
  localparam logic [2:0] KIND_SL2 = 3'h2;
  localparam logic [2:0] KIND_SL3 = 3'h3;
  localparam logic [2:0] KIND_SL5 = 3'h5;
  localparam logic [2:0] KIND_RSVD_A = 3'h6;
  localparam logic [2:0] KIND_RSVD_B = 3'h7;

  typedef enum logic [2:0] {
    ASLC_WORK = 3'b001,
    ASLC_WAIT_SMI = 3'b010,
    ASLC_SLEEPING = 3'b100
  } aslc_state_t;
endpackage

//--- rtl/aslc_w1c_bits.sv
`timescale 1ns/1ps
module aslc_w1c_bits #(
  parameter int W = 8,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Set and clear
  input wire logic [W-1:0] set_bits,
  input wire logic [W-1:0] clr_bits,
  // State
  output logic [W-1:0] flags
);
  // Set wins over a clear landing in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      flags <= RESET_VAL;
    end else begin
      flags <= (flags & ~clr_bits) | set_bits; // RQ15
    end
  end
endmodule // aslc_w1c_bits

//--- rtl/aslc_pin_sync.sv
`timescale 1ns/1ps
module aslc_pin_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Pin and clean level
  input wire logic pin_in,
  output logic level_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // A change counts only once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end
endmodule // aslc_pin_sync

//--- verification/aslc_sleep_lock_ctrl_assertions.sv
`timescale 1ns/1ps
module aslc_sleep_lock_ctrl_assertions (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_addr,
  input wire logic [1:0] io_be,
  input wire logic [15:0] io_wdata,
  input wire logic [15:0] io_rdata,
  // Events and results
  input wire logic [15:0] gen_event_in,
  input wire logic smi_serviced,
  input wire logic cpu_in_c3,
  input wire logic force_c0,
  input wire logic management_interrupt,
  input wire logic smi_top_status_set,
  input wire logic smi_top_legacy_set,
  input wire logic smi_second_lock_set,
  input wire logic system_control_interrupt,
  input wire logic power_mgmt_event,
  input wire logic sleep_active,
  input wire logic [2:0] sleep_kind_out
);
  logic irq_en_shadow;
  logic bm_en;
  logic fw_en;
  wire logic wr_ctl = io_wr && io_addr == 8'h0c && io_be[0];
  // ----
  // Shadow enables, since the design keeps its own hidden
  // ----
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      irq_en_shadow <= 1'b0;
      bm_en <= 1'b0;
    end else if (wr_ctl) begin
      irq_en_shadow <= io_wdata[0];
      bm_en <= io_wdata[1];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!resetn) fw_en <= 1'b0;
    else if (io_wr && io_addr == 8'h0e && io_be[1]) fw_en <= io_wdata[8];
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_rls_wr;
    wr_ctl && io_wdata[2];
  endsequence
  sequence s_fw_lock_wr;
    io_wr && io_addr == 8'h0e && io_be[1] && io_wdata[9];
  endsequence
  a_rls_smi_on: assert property (
    s_rls_wr ##0 fw_en |=> management_interrupt && smi_top_status_set && smi_second_lock_set)
    else $error("release gave no smi");
  a_rls_smi_off: assert property (
    s_rls_wr ##0 !fw_en |=> !smi_top_status_set && !smi_second_lock_set)
    else $error("release smi while disabled");
  a_lock_event: assert property (
    s_fw_lock_wr |=> power_mgmt_event) else $error("lock release gave no event");
  a_legacy_smi: assert property (
    !irq_en_shadow && |(gen_event_in & 16'h077d) |=> management_interrupt && smi_top_legacy_set)
    else $error("legacy event gave no smi");
  a_acpi_no_legacy: assert property (
    irq_en_shadow |=> !smi_top_legacy_set) else $error("legacy smi in acpi mode");
  a_sci_gated: assert property (
    !irq_en_shadow && !$past(irq_en_shadow) |-> !system_control_interrupt)
    else $error("sci while disabled");
  a_c3_exit: assert property (
    force_c0 |-> $past(bm_en) && $past(cpu_in_c3)) else $error("c0 forced without cause");
  a_sleep_after_smi: assert property (
    $rose(sleep_active) |-> $past(smi_serviced)) else $error("sleep without serviced smi");
  a_sleep_kind_ok: assert property (
    sleep_active |-> !(sleep_kind_out inside {3'h0, 3'h6, 3'h7}))
    else $error("sleeping in bad kind");
  a_wo_reads: assert property (
    io_rd && io_addr == 8'h0c |=> !io_rdata[13] && !io_rdata[2])
    else $error("write-only bit read back");
endmodule // aslc_sleep_lock_ctrl_assertions

bind aslc_sleep_lock_ctrl aslc_sleep_lock_ctrl_assertions u_chk (.clk_sys, .resetn, .io_wr,
  .io_rd, .io_addr, .io_be, .io_wdata, .io_rdata, .gen_event_in, .smi_serviced, .cpu_in_c3,
  .force_c0, .management_interrupt, .smi_top_status_set, .smi_top_legacy_set,
  .smi_second_lock_set, .system_control_interrupt, .power_mgmt_event, .sleep_active,
  .sleep_kind_out);

//--- verification/aslc_sw_model.sv
`timescale 1ns/1ps
module aslc_sw_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Firmware handler
  input wire logic management_interrupt,
  input wire logic slow,
  output logic smi_serviced
);
  int cnt;
  // Handler latency, short or long, before reporting service
  always_ff @(posedge clk_sys) begin
    smi_serviced <= 1'b0;
    if (!resetn) cnt <= 0;
    else if (management_interrupt) cnt <= slow ? 8 : 2;
    else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) smi_serviced <= 1'b1;
    end
  end
endmodule // aslc_sw_model

//--- verification/aslc_sleep_lock_ctrl_tb.sv
`timescale 1ns/1ps
module aslc_sleep_lock_ctrl_tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_addr = 8'h00;
  logic [1:0] io_be = 2'h0;
  logic [15:0] io_wdata = 16'h0000;
  logic [15:0] io_rdata;
  logic [15:0] gen_event_in = 16'h0000;
  logic [15:0] gen_event_enable = 16'h0000;
  logic smi_serviced;
  logic wake_event = 1'b0;
  logic cpu_in_c3 = 1'b0;
  logic bm_pin = 1'b0;
  logic slow = 1'b0;
  logic force_c0;
  logic management_interrupt;
  logic system_control_interrupt;
  logic sleep_active;
  logic [2:0] sleep_kind_out;
  int n_mismatch = 0;
  int comparisons = 0;
  int seed = 32'h5f4b8c66;
  int hits;
  logic [15:0] gpe;

  aslc_sleep_lock_ctrl dut (.clk_sys, .resetn, .io_wr, .io_rd, .io_addr, .io_be, .io_wdata,
    .io_rdata, .gen_event_in, .gen_event_enable, .smi_serviced, .wake_event, .cpu_in_c3,
    .bus_master_req_pin(bm_pin), .force_c0, .management_interrupt, .smi_top_status_set(),
    .smi_top_legacy_set(), .smi_second_lock_set(), .system_control_interrupt,
    .power_mgmt_event(), .sleep_active, .sleep_kind_out);
  aslc_sw_model u_fw (.clk_sys, .resetn, .management_interrupt, .slow, .smi_serviced);

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  // ----
  // Bus cycles and checking
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Event pulse rides with the write so set and clear can collide
  task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d,
      input logic [15:0] ev);
    tick(1);
    io_wr = 1'b1;
    io_addr = a;
    io_be = be;
    io_wdata = d;
    gen_event_in = ev;
    tick(1);
    io_wr = 1'b0;
    gen_event_in = 16'h0000;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    tick(1);
    io_rd = 1'b1;
    io_addr = a;
    tick(1);
    io_rd = 1'b0;
    d = io_rdata;
  endtask
  function automatic logic [15:0] gpe_next(input logic [15:0] s, input logic [15:0] ev,
      input logic [15:0] clr, input logic [1:0] be);
    return (s & ~(clr & {{8{be[1]}}, {8{be[0]}}})) | (ev & 16'h077d);
  endfunction
  function automatic logic [15:0] sleeps(input logic [2:0] k);
    return {15'h0, !(k inside {3'h0, 3'h6, 3'h7})};
  endfunction
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    finish_test;
  end

  // ----
  // Main sequence
  // ----
  initial begin
    logic [15:0] v;
    logic [15:0] ev;
    logic [15:0] clr;
    logic [1:0] be;
    gen_event_enable = 16'($random(seed));
    tick(10);
    resetn = 1'b1;
    rd(8'h0c, v);
    chk(v, 16'h0000);
    rd(8'h0e, v);
    chk(v, 16'h0000);
    rd(8'h20, v);
    chk(v, 16'h0000);
    done("reset");
    wr(8'h0c, 2'h3, 16'h3c07, 16'h0000);
    rd(8'h0c, v);
    chk(v, 16'h1c03);
    chk(16'(sleep_active), 16'h0000);
    rd(8'h0e, v);
    chk(v, 16'h0001);
    wr(8'h0e, 2'h1, 16'h0001, 16'h0000);
    rd(8'h0e, v);
    chk(v, 16'h0000);
    wr(8'h0e, 2'h2, 16'h0300, 16'h0000);
    rd(8'h0e, v);
    chk(v, 16'h0100);
    rd(8'h08, v);
    chk(v, 16'h0020);
    wr(8'h0a, 2'h3, 16'h0020, 16'h0000);
    tick(2);
    chk(16'(system_control_interrupt), 16'h0001);
    wr(8'h08, 2'h3, 16'h0020, 16'h0000);
    tick(2);
    chk(16'(system_control_interrupt), 16'h0000);
    done("registers");
    wr(8'h0c, 2'h3, 16'h0000, 16'h0000);
    gpe = 16'h0000;
    for (int i = 0; i < 24; i++) begin
      ev = (i == 0) ? 16'hffff : 16'($random(seed));
      clr = (i < 2) ? 16'hffff : 16'($random(seed));
      be = (i < 2) ? 2'h3 : 2'($random(seed));
      wr(8'h10, be, clr, ev);
      gpe = gpe_next(gpe, ev, clr, be);
      rd(8'h10, v);
      chk(v, gpe);
    end
    done("general events");
    for (int k = 0; k < 8; k++) begin
      slow = k[0];
      wr(8'h0c, 2'h3, {2'b00, 1'b1, k[2:0], 10'h001}, 16'h0000);
      wr(8'h0c, 2'h1, 16'h0005, 16'h0000);
      hits = 0;
      while (!sleep_active && hits < 20) begin
        tick(1);
        hits++;
      end
      chk(16'(sleep_active), sleeps(k[2:0]));
      chk(16'(sleep_kind_out), sleeps(k[2:0]) * k[2:0]);
      wake_event = 1'b1;
      tick(1);
      wake_event = 1'b0;
      tick(2);
      chk(16'(sleep_active), 16'h0000);
    end
    done("sleep");
    cpu_in_c3 = 1'b1;
    for (int m = 1; m >= 0; m--) begin
      wr(8'h0c, 2'h1, {14'h0, m[0], 1'b1}, 16'h0000);
      bm_pin = 1'b1;
      hits = 0;
      repeat (12) begin
        tick(1);
        hits += int'(force_c0);
      end
      bm_pin = 1'b0;
      tick(6);
      chk(16'(hits), 16'(m));
    end
    done("c3 exit");
    wr(8'h0c, 2'h1, 16'h0004, 16'h0000);
    rd(8'h0e, v);
    chk(v, 16'h0101);
    resetn = 1'b0;
    tick(3);
    resetn = 1'b1;
    rd(8'h0e, v);
    chk(v, 16'h0000);
    wr(8'h0e, 2'h2, 16'h0100, 16'h0000);
    wr(8'h0c, 2'h2, 16'h2400, 16'h0000);
    wr(8'h0c, 2'h1, 16'h0004, 16'h0000);
    tick(20);
    chk(16'(sleep_active), 16'h0000);
    done("reset again");
    finish_test;
  end
endmodule // aslc_sleep_lock_ctrl_tb
